/* inc/ipf_pkg.sv */
// package of register map, field layouts and carrier types for the interrupt priority flags
package ipf_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] IPF_CTRL_OFS = 8'h00;
	localparam logic [7:0] IPF_RELOAD_OFS = 8'h04;
	localparam logic [7:0] IPF_TIMER_OFS = 8'h08;
	localparam logic [7:0] IPF_FLAG_OFS = 8'h0C;
	localparam logic [7:0] IPF_ENABLE_OFS = 8'h10;
	localparam logic [7:0] IPF_EVT_STAT_OFS = 8'h14;
	localparam logic [7:0] IPF_EVT_MASK_OFS = 8'h18;
	localparam logic [7:0] IPF_CORE_STAT_OFS = 8'h1C;
	localparam logic [7:0] IPF_PRIO_BASE_OFS = 8'h20;
	localparam logic [7:0] IPF_PRIO_LAST_OFS = 8'h3C;

	// sizes
	localparam int IPF_SOURCES = 32;
	localparam int IPF_PRIO_REGS = 8;
	localparam int IPF_SLOT_BITS = 8;

	// control register fields
	localparam int IPF_MULTI_VECTOR_SELECT_BIT = 12;
	localparam int IPF_THR_LSB = 8;
	localparam logic [31:0] IPF_CTRL_MASK = 32'h0000170F & 32'h00001700;

	// priority slot layout inside each byte
	localparam int IPF_PRIO_LSB = 2;
	localparam int IPF_SUB_LSB = 0;
	localparam logic [31:0] IPF_PRIO_IMPL_MASK = 32'h1F1F1F1F;

	// event status bits
	localparam int IPF_EVT_BITS = 2;
	localparam int IPF_EVT_NEWREQ = 0;
	localparam int IPF_EVT_EXPIRE = 1;

	// reset values
	localparam logic [31:0] IPF_RESET_WORD = 32'h00000000;

	// AXI responses
	localparam logic [1:0] IPF_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPF_RESP_SLVERR = 2'h2;

	// winner of arbitration, registered into the request the core sees
	typedef struct packed {
		logic valid;
		logic [2:0] level;
		logic [1:0] sub;
		logic [4:0] source;
	} ipf_win_s;

	// request presented to the processor core
	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic [1:0] sub;
		logic [4:0] vector;
	} ipf_core_s;

endpackage : ipf_pkg

/* logic/ipf_interrupt_priority_flags.sv */
// per-source interrupt flags, enables, priorities, proximity reload and AXI4-Lite slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ipf_interrupt_priority_flags
	import ipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	// peripheral request pulses, same clock
	input wire logic [31:0] srcReq,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// prioritized request to the core
	output ipf_core_s coreReq,
	// block interrupt
	output logic irq
);

	// merge a write word into an old word under byte strobes
	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : mergeStrb

	// true when an address hits a mapped register
	function automatic logic isMapped(input logic [7:0] addr);
		return (addr[1:0] == 2'h0) && (addr <= IPF_PRIO_LAST_OFS);
	endfunction : isMapped

	// highest priority, then highest subpriority, ties to lowest source
	function automatic ipf_win_s pickWinner(input logic [31:0] pend,
		input logic [IPF_PRIO_REGS-1:0][31:0] prio);
		ipf_win_s best;
		logic [7:0] slot;
		best = '0;
		for (int i = 0; i < IPF_SOURCES; i++) begin
			slot = prio[i/4][(i%4)*IPF_SLOT_BITS +: IPF_SLOT_BITS];
			if (pend[i] && (slot[IPF_PRIO_LSB +: 3] != 3'h0) &&
				(!best.valid || (slot[4:0] > {best.level, best.sub}))) begin
				best.valid = 1'b1;
				best.level = slot[IPF_PRIO_LSB +: 3];
				best.sub = slot[IPF_SUB_LSB +: 2];
				best.source = 5'(i);
			end
		end
		return best;
	endfunction : pickWinner

	// register file
	logic [31:0] ctrl_ff; // multi-vector and threshold
	logic [31:0] reload_ff; // proximity reload word
	logic [31:0] timer_ff; // proximity countdown
	logic [31:0] flags_ff; // request flags, one per source
	logic [31:0] enables_ff; // source enables
	logic [IPF_PRIO_REGS-1:0][31:0] prio_ff; // priority slots
	logic [IPF_EVT_BITS-1:0] evtStat_ff; // sticky events
	logic [IPF_EVT_BITS-1:0] evtMask_ff; // event mask
	ipf_core_s core_ff; // what the core sees
	logic winValidPrev_ff; // for new-winner detection
	logic [4:0] winSrcPrev_ff;

	// write channel holding registers
	logic awHeld_ff;
	logic [7:0] awAddr_ff;
	logic wHeld_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic bValid_ff;
	logic [1:0] bResp_ff;
	// read channel
	logic rValid_ff;
	logic [31:0] rData_ff;
	logic [1:0] rResp_ff;

	// handshakes: one write and one read in flight at most
	assign s_axi_awready = !awHeld_ff && !bValid_ff;
	assign s_axi_wready = !wHeld_ff && !bValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_arready = !rValid_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;

	// write happens once both address and data are held
	wire logic doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	wire logic wrMapped = isMapped(awAddr_ff);
	wire logic wrCtrl = doWrite && (awAddr_ff == IPF_CTRL_OFS);
	wire logic wrReload = doWrite && (awAddr_ff == IPF_RELOAD_OFS);
	wire logic wrFlag = doWrite && (awAddr_ff == IPF_FLAG_OFS);
	wire logic wrEnable = doWrite && (awAddr_ff == IPF_ENABLE_OFS);
	wire logic wrEvtStat = doWrite && (awAddr_ff == IPF_EVT_STAT_OFS);
	wire logic wrEvtMask = doWrite && (awAddr_ff == IPF_EVT_MASK_OFS);
	wire logic wrPrio = doWrite && (awAddr_ff >= IPF_PRIO_BASE_OFS) && wrMapped;
	wire logic [2:0] wrPrioIdx = 3'(awAddr_ff[4:2]);

	// strobe-merged write words
	wire logic [31:0] ctrlMerged = mergeStrb(ctrl_ff, wData_ff, wStrb_ff) & IPF_CTRL_MASK;
	wire logic [31:0] flagMerged = mergeStrb(flags_ff, wData_ff, wStrb_ff);
	wire logic [31:0] prioMerged = mergeStrb(prio_ff[wrPrioIdx], wData_ff, wStrb_ff);
	wire logic [31:0] strbMask = mergeStrb(32'h00000000, 32'hFFFFFFFF, wStrb_ff);
	// mask word widened for the merge, cut back to the event bits when stored
	wire logic [31:0] maskMerged = mergeStrb(32'(evtMask_ff), wData_ff, wStrb_ff);

	// control fields
	wire logic multiVectorSelect = ctrl_ff[IPF_MULTI_VECTOR_SELECT_BIT];
	wire logic [2:0] proximityThreshold = ctrl_ff[IPF_THR_LSB +: 3];

	// pending: flagged and enabled; priority zero drops out in the arbiter
	wire logic [31:0] pending = flags_ff & enables_ff;
	wire ipf_win_s winner = pickWinner(pending, prio_ff);

	// a new winner is an interrupt event toward the core
	wire logic newWinner = winner.valid &&
		(!winValidPrev_ff || (winner.source != winSrcPrev_ff));
	// threshold n lets priorities n and below start the timer, 0 disables
	wire logic thrHit = (proximityThreshold != 3'h0) &&
		(winner.level <= proximityThreshold);
	wire logic timerTrigger = newWinner && thrHit;
	wire logic timerExpire = (timer_ff == 32'h00000001) && !timerTrigger;

	// event sources into sticky status
	wire logic [IPF_EVT_BITS-1:0] evtSet = {timerExpire, newWinner};
	wire logic [IPF_EVT_BITS-1:0] evtClr =
		wrEvtStat ? (wData_ff[IPF_EVT_BITS-1:0] & strbMask[IPF_EVT_BITS-1:0]) : '0;

	// read decode on the incoming read address
	wire logic [7:0] rdAddr = s_axi_araddr;
	wire logic rdMapped = isMapped(rdAddr);
	wire logic [2:0] rdPrioIdx = 3'(rdAddr[4:2]);
	logic [31:0] rdWord;

	// read multiplexer; unmapped words read zero
	always_comb begin
		rdWord = 32'h00000000;
		if (rdMapped && (rdAddr >= IPF_PRIO_BASE_OFS)) begin
			rdWord = prio_ff[rdPrioIdx] & IPF_PRIO_IMPL_MASK;
		end else begin
			unique case (rdAddr)
				IPF_CTRL_OFS: rdWord = ctrl_ff;
				IPF_RELOAD_OFS: rdWord = reload_ff;
				IPF_TIMER_OFS: rdWord = timer_ff;
				IPF_FLAG_OFS: rdWord = flags_ff;
				IPF_ENABLE_OFS: rdWord = enables_ff;
				IPF_EVT_STAT_OFS: rdWord = 32'(evtStat_ff);
				IPF_EVT_MASK_OFS: rdWord = 32'(evtMask_ff);
				IPF_CORE_STAT_OFS: rdWord = 32'(core_ff);
				default: rdWord = 32'h00000000;
			endcase
		end
	end

	// axi write channel: take address and data in either order
	always_ff @(posedge clk) begin
		if (srst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
			bValid_ff <= 1'b0;
			bResp_ff <= IPF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (doWrite) begin
				// slot frees up only after the response is taken
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				bValid_ff <= 1'b1;
				bResp_ff <= wrMapped ? IPF_RESP_OKAY : IPF_RESP_SLVERR;
			end else if (bValid_ff && s_axi_bready) begin
				bValid_ff <= 1'b0;
			end
		end
	end

	// axi read channel: data registered one cycle after the address
	always_ff @(posedge clk) begin
		if (srst) begin
			rValid_ff <= 1'b0;
			rData_ff <= 32'h00000000;
			rResp_ff <= IPF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_ff <= 1'b1;
			rData_ff <= rdWord;
			rResp_ff <= rdMapped ? IPF_RESP_OKAY : IPF_RESP_SLVERR;
		end else if (rValid_ff && s_axi_rready) begin
			rValid_ff <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff <= IPF_RESET_WORD;
			reload_ff <= IPF_RESET_WORD;
			enables_ff <= IPF_RESET_WORD;
			evtMask_ff <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= ctrlMerged;
			end
			if (wrReload) begin
				reload_ff <= mergeStrb(reload_ff, wData_ff, wStrb_ff);
			end
			if (wrEnable) begin
				enables_ff <= mergeStrb(enables_ff, wData_ff, wStrb_ff);
			end
			if (wrEvtMask) begin
				evtMask_ff <= maskMerged[IPF_EVT_BITS-1:0];
			end
		end
	end

	// priority slots; unimplemented bits never stored
	always_ff @(posedge clk) begin
		if (srst) begin
			prio_ff <= '0;
		end else if (wrPrio) begin
			prio_ff[wrPrioIdx] <= prioMerged & IPF_PRIO_IMPL_MASK;
		end
	end

	// request flags: a source request beats a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_ff <= IPF_RESET_WORD;
		end else begin
			flags_ff <= (wrFlag ? flagMerged : flags_ff) | srcReq;
		end
	end

	// proximity timer: reload on a qualifying event, else count to zero
	always_ff @(posedge clk) begin
		if (srst) begin
			timer_ff <= IPF_RESET_WORD;
		end else if (timerTrigger) begin
			timer_ff <= reload_ff;
		end else if (timer_ff != 32'h00000000) begin
			timer_ff <= timer_ff - 32'h00000001;
		end
	end

	// sticky events: a set in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (srst) begin
			evtStat_ff <= '0;
		end else begin
			evtStat_ff <= (evtStat_ff & ~evtClr) | evtSet;
		end
	end

	// presentation to the core; single-vector mode always shows vector 0
	always_ff @(posedge clk) begin
		if (srst) begin
			core_ff <= '0;
			winValidPrev_ff <= 1'b0;
			winSrcPrev_ff <= 5'h00;
		end else begin
			core_ff.req <= winner.valid;
			core_ff.level <= winner.level;
			core_ff.sub <= winner.sub;
			core_ff.vector <= multiVectorSelect ? winner.source : 5'h00;
			winValidPrev_ff <= winner.valid;
			winSrcPrev_ff <= winner.source;
		end
	end

	// outputs
	assign coreReq = core_ff;
	// level interrupt, high while an unmasked event bit is set
	assign irq = |(evtStat_ff & evtMask_ff);

endmodule : ipf_interrupt_priority_flags
`default_nettype wire

/* test/ipf_core_model.sv */
// processor core model that records the vector of each request it sees
`timescale 1ns/1ps
`default_nettype none
module ipf_core_model
	import ipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire ipf_core_s coreReq,
	output logic [4:0] lastVector_ff
);
	// the core only watches; the request stands until software drops it
	always_ff @(posedge clk) begin
		if (srst) begin
			lastVector_ff <= 5'h00;
		end else if (coreReq.req) begin
			lastVector_ff <= coreReq.vector;
		end
	end
endmodule : ipf_core_model
`default_nettype wire

/* test/ipf_properties.sv */
// handshake and request checker for the interrupt priority flags block
`timescale 1ns/1ps
`default_nettype none
module ipf_properties
	import ipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire ipf_core_s coreReq,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// write answer stands until taken
	chk_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	// read data frozen while waiting
	chk_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	// read answered one cycle after address
	chk_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	// no new read while one is open
	chk_ar_blocked: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("arready during read");
	// no new write while answer pending
	chk_w_blocked: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
	// write answered within two cycles of both handshakes
	chk_b_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("late write answer");
	// level zero never reaches the core
	chk_level_nonzero: assert property (
		coreReq.req |-> coreReq.level != 3'h0) else $error("zero level presented");
	// reset clears irq, the core request and the write answer
	chk_reset_quiet: assert property (
		@(posedge clk) disable iff (1'b0) srst |=> !irq && !coreReq.req && !s_axi_bvalid)
		else $error("state after reset");
endmodule : ipf_properties
bind ipf_interrupt_priority_flags ipf_properties u_ipf_properties (.clk, .srst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .coreReq, .irq);
`default_nettype wire

/* test/tb_interrupt_priority_flags.sv */
// self-checking bench for the interrupt priority flags block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin badCount++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_interrupt_priority_flags
	import ipf_pkg::*;
;
	logic clk, srst, irq;
	logic [31:0] srcReq, s_axi_wdata, s_axi_rdata, f, e, r, d;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	ipf_core_s coreReq;
	logic [4:0] lastVector_ff;
	logic [7:0][31:0] p; // shadow of the priority words
	logic [10:0] w;
	logic [7:0] ofs [0:4] = '{IPF_CTRL_OFS, IPF_RELOAD_OFS, IPF_FLAG_OFS, IPF_ENABLE_OFS,
		IPF_PRIO_BASE_OFS};
	int badCount, numChecks, k;

	ipf_interrupt_priority_flags u_ipf_interrupt_priority_flags (.clk, .srst, .srcReq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coreReq, .irq);
	ipf_core_model u_ipf_core_model (.clk, .srst, .coreReq, .lastVector_ff);

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// verdict, reached from the sequence or the watchdog
	task automatic finalReport();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finalReport

	// write cycle; both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no count of its own: a missing answer is left to the watchdog
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				`CHK(s_axi_bresp, er)
				break;
			end
		end
	endtask : wr

	// read cycle; waits for the answer, a hang ends in the watchdog
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 'x;
		forever begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				v = s_axi_rdata;
				`CHK(s_axi_rresp, er)
				break;
			end
		end
	endtask : rd

	task automatic wrOk(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, 4'hF, IPF_RESP_OKAY);
	endtask : wrOk

	// expected core request; strict compare keeps the lowest index on ties
	function automatic logic [10:0] expWinner(input logic [31:0] fl, input logic [31:0] en,
		input logic [7:0][31:0] pr, input logic mv);
		logic [10:0] best;
		logic [4:0] slot;
		best = '0;
		for (int i = 0; i < 32; i++) begin
			slot = pr[i / 4][8 * (i % 4) +: 5];
			if (fl[i] && en[i] && slot[4:2] != 3'h0 && (!best[10] || slot > best[9:5])) begin
				best = {1'b1, slot, mv ? 5'(i) : 5'h00};
			end
		end
		return best;
	endfunction : expWinner

	// watchdog well past the expected 1250 or so cycles
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		finalReport();
	end

	// main sequence
	initial begin
		void'($urandom(16));
		{srst, srcReq, s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {1'b1, 76'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_araddr} = 11'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// stored registers come up cleared
		for (k = 0; k < 5; k++) begin
			rd(ofs[k], IPF_RESP_OKAY, d);
			`CHK(d, IPF_RESET_WORD)
		end
		`CHK({irq, coreReq}, 12'h000)
		// reload takes any word; strobe merges one byte
		r = $urandom();
		wrOk(IPF_RELOAD_OFS, r);
		wr(IPF_RELOAD_OFS, ~r, 4'h1, IPF_RESP_OKAY);
		rd(IPF_RELOAD_OFS, IPF_RESP_OKAY, d);
		`CHK(d, {r[31:8], ~r[7:0]})
		// top slot bits ignore writes
		wrOk(IPF_PRIO_LAST_OFS, 32'hFFFFFFFF);
		rd(IPF_PRIO_LAST_OFS, IPF_RESP_OKAY, d);
		`CHK(d, IPF_PRIO_IMPL_MASK)
		// unmapped read and misaligned write refused
		rd(8'h40, IPF_RESP_SLVERR, d);
		`CHK(d, 32'h00000000)
		wr(8'h05, r, 4'hF, IPF_RESP_SLVERR);
		// one-cycle pulse sets only its own flag
		k = $urandom_range(31);
		srcReq <= 32'h1 << k;
		@(posedge clk);
		srcReq <= '0;
		rd(IPF_FLAG_OFS, IPF_RESP_OKAY, d);
		`CHK(d, 32'h1 << k)
		// random arbitration rounds, the first with every level zero
		for (int t = 0; t < 24; t++) begin
			for (int j = 0; j < 8; j++) begin
				r = (t == 0) ? 32'h0 : $urandom();
				p[j] = r & IPF_PRIO_IMPL_MASK;
				wrOk(IPF_PRIO_BASE_OFS + 8'(4 * j), r);
			end
			f = $urandom() & $urandom();
			e = $urandom();
			wrOk(IPF_CTRL_OFS, {19'h0, t[0], 12'h000});
			wrOk(IPF_ENABLE_OFS, e);
			wrOk(IPF_FLAG_OFS, f);
			repeat (2) @(posedge clk);
			w = expWinner(f, e, p, t[0]);
			`CHK(coreReq, w)
			if (w[10]) `CHK(lastVector_ff, w[4:0])
		end
		// unmapped addresses alias no priority word, now that slot 0 is busy
		rd(8'h41, IPF_RESP_SLVERR, d);
		`CHK(d, 32'h00000000)
		rd(8'h60, IPF_RESP_SLVERR, d);
		`CHK(d, 32'h00000000)
		// event interrupt masked in, raised, cleared; proximity timer runs out
		wrOk(IPF_FLAG_OFS, 32'h0);
		wrOk(IPF_EVT_STAT_OFS, 32'h3);
		wrOk(IPF_EVT_MASK_OFS, 32'h1);
		`CHK(irq, 1'b0)
		wrOk(IPF_PRIO_BASE_OFS, 32'h00000400);
		wrOk(IPF_ENABLE_OFS, 32'h3);
		wrOk(IPF_RELOAD_OFS, 32'd40);
		wrOk(IPF_CTRL_OFS, 32'h00000700);
		wrOk(IPF_FLAG_OFS, 32'h2);
		repeat (2) @(posedge clk);
		// new-winner event is unmasked, so irq stands beside the level-one request
		`CHK({irq, coreReq}, 12'hC80)
		rd(IPF_TIMER_OFS, IPF_RESP_OKAY, d);
		`CHK(d <= 32'd40 && d != 32'h0, 1'b1)
		repeat (50) @(posedge clk);
		rd(IPF_EVT_STAT_OFS, IPF_RESP_OKAY, d);
		`CHK(d, 32'h3)
		wrOk(IPF_EVT_STAT_OFS, 32'h1);
		`CHK(irq, 1'b0)
		finalReport();
	end
endmodule : tb_interrupt_priority_flags
`default_nettype wire
